// file: hdl/input_filter_demo_limits.sv
`timescale 1ns/100ps
`default_nettype none

module input_filter_demo_limits
  import input_filter_demo_limits_pkg::*;
#(
  parameter int NUM_DIN = 9,
  parameter int NUM_MEAS = 8,
  parameter int NUM_GEN = 3,
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
)(
  input wire logic core_clk, // System clock, 10 MHz.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic [NUM_DIN-1:0] dinPin, // Raw binary input pins.
  input wire logic filtWrEn, // Load one debounce interval.
  input wire logic [3:0] filtWrIdx, // Input whose interval is loaded.
  input wire logic [TIME_W-1:0] filtWrTime, // Interval in milliseconds.
  input wire logic genWrEn, // Load one generator configuration.
  input wire logic [1:0] genWrIdx, // Generator being loaded.
  input wire logic [2:0] genWrShape, // One-hot shape code.
  input wire logic signed [15:0] genWrMin, // Minimum level.
  input wire logic signed [15:0] genWrMax, // Maximum level.
  input wire logic [TIME_W-1:0] genWrPeriod, // Period in milliseconds.
  input wire logic [TIME_W-1:0] genWrHigh, // Rectangle high time, ms.
  input wire logic [TIME_W-1:0] genWrRise, // Triangle rise time, ms.
  input wire logic signed [15:0] genWrLoLim, // Generator low limit.
  input wire logic signed [15:0] genWrHiLim, // Generator high limit.
  input wire logic [NUM_MEAS-1:0][15:0] measValue, // Measured values, signed.
  input wire logic [NUM_MEAS-1:0][15:0] measLoLim, // Low limits, signed.
  input wire logic [NUM_MEAS-1:0][15:0] measHiLim, // High limits, signed.
  input wire logic signed [15:0] ntcLnR, // ln(R), 8 fraction bits.
  input wire logic signed [31:0] ntcCoefA, // A scaled by 2^32.
  input wire logic signed [31:0] ntcCoefB, // B scaled by 2^32.
  input wire logic signed [31:0] ntcCoefC, // C scaled by 2^40.
  input wire logic signed [15:0] ntcLoLim, // Low limit, 0.1 degC.
  input wire logic signed [15:0] ntcHiLim, // High limit, 0.1 degC.
  output logic [NUM_DIN-1:0] dinState, // Filtered input states.
  output logic [NUM_GEN-1:0][15:0] genValue, // Generator outputs, signed.
  output logic [NUM_GEN-1:0] genBelow, // below_limit_flag per generator.
  output logic [NUM_GEN-1:0] genAbove, // above_limit_flag per generator.
  output logic [NUM_MEAS-1:0] measBelow, // below_limit_flag per input.
  output logic [NUM_MEAS-1:0] measAbove, // above_limit_flag per input.
  output logic [15:0] ntcTemp // Temperature, 0.1 degC, signed.
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [NUM_DIN-1:0] dinMeta;
    logic [NUM_DIN-1:0] dinSync;
    logic [NUM_DIN-1:0] dinState;
    logic [NUM_DIN-1:0][TIME_W-1:0] filt;
    logic [NUM_DIN-1:0][TIME_W-1:0] cnt;
    logic [TICK_CNT_W-1:0] tickCnt;
    logic tick;
    genCfg_t [NUM_GEN-1:0] gen;
    logic [NUM_GEN-1:0][TIME_W-1:0] phase;
    logic [NUM_GEN-1:0][15:0] genOut;
    logic [NUM_GEN-1:0] genBelow;
    logic [NUM_GEN-1:0] genAbove;
    logic [NUM_MEAS-1:0] measBelow;
    logic [NUM_MEAS-1:0] measAbove;
    logic [15:0] ntcTemp;
  } state_t;

  localparam state_t ST_RST = '{gen: {NUM_GEN{GEN_CFG_RST}}, default: '0};

  state_t st_r;
  state_t st_nxt;
  logic [1:0] rstPipe;
  logic rstN;
  genCfg_t cfgNew;
  logic [SINE_IDX_W-1:0] sineIdx;
  logic [1:0] flags;
  logic signed [95:0] ntcX;
  logic signed [95:0] ntcX3;
  logic signed [95:0] ntcDen;
  logic signed [95:0] ntcCel;

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------

  // Point on a straight line from one level to another; used by the
  // triangle edges and the sine so that those two shapes share one divider form.
  function automatic logic signed [15:0] rampPoint(
    input logic signed [15:0] fromLvl,
    input logic signed [15:0] toLvl,
    input logic [TIME_W-1:0] num,
    input logic [TIME_W-1:0] den
  );
    logic signed [41:0] diff;
    logic signed [41:0] q;
    diff = 42'(toLvl) - 42'(fromLvl);
    q = (diff * $signed({22'h000000, num})) / $signed({22'h000000, den | 20'h00001});
    if (den == 20'h00000)
    begin
      rampPoint = toLvl;
    end
    else
    begin
      rampPoint = 16'(42'(fromLvl) + q);
    end
  endfunction

  // Quarter sine, 256 * sin(k * pi / 32) for k = 0..16.
  function automatic logic [8:0] quarterSine(input logic [4:0] k);
    logic [8:0] t;
    unique case (k)
      5'h00: t = 9'h000;
      5'h01: t = 9'h019;
      5'h02: t = 9'h032;
      5'h03: t = 9'h04A;
      5'h04: t = 9'h062;
      5'h05: t = 9'h079;
      5'h06: t = 9'h08E;
      5'h07: t = 9'h0A2;
      5'h08: t = 9'h0B5;
      5'h09: t = 9'h0C6;
      5'h0A: t = 9'h0D5;
      5'h0B: t = 9'h0E2;
      5'h0C: t = 9'h0ED;
      5'h0D: t = 9'h0F5;
      5'h0E: t = 9'h0FB;
      5'h0F: t = 9'h0FF;
      default: t = 9'h100;
    endcase
    return t;
  endfunction

  // Full sine as an offset value 0..512, mid level at index zero.
  function automatic logic [9:0] sineLut(input logic [SINE_IDX_W-1:0] idx);
    logic [4:0] k;
    logic [9:0] s;
    k = {1'b0, idx[3:0]};
    unique case (idx[5:4])
      2'h0: s = SINE_MID + 10'(quarterSine(k));
      2'h1: s = SINE_MID + 10'(quarterSine(5'h10 - k));
      2'h2: s = SINE_MID - 10'(quarterSine(k));
      default: s = SINE_MID - 10'(quarterSine(5'h10 - k));
    endcase
    return s;
  endfunction

  // Limit comparison shared by generators and measured inputs.
  function automatic logic [1:0] limitFlags(
    input logic signed [15:0] v,
    input logic signed [15:0] lo,
    input logic signed [15:0] hi
  );
    return {v > hi, v < lo};
  endfunction

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------

  // Reset asserts at once but releases on the clock, so no flop sees a
  // release near its edge.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rstPipe <= 2'b00;
    end
    else
    begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end

  assign rstN = rstPipe[1];

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    cfgNew = '{shape: shape_t'(genWrShape), minLvl: genWrMin, maxLvl: genWrMax,
               period: genWrPeriod, highTime: genWrHigh, riseTime: genWrRise,
               loLim: genWrLoLim, hiLim: genWrHiLim};
    sineIdx = '0;
    flags = 2'b00;
    ntcX = '0;
    ntcX3 = '0;
    ntcDen = '0;
    ntcCel = '0;

    // Pins pass two flops; only the second one is looked at.
    st_nxt.dinMeta = dinPin;
    st_nxt.dinSync = st_r.dinMeta;

    // Millisecond time base for all intervals and waveforms.
    if (st_r.tickCnt == TICK_CNT_W'(TICK_CYCLES - 1))
    begin
      st_nxt.tickCnt = '0;
      st_nxt.tick = 1'b1;
    end
    else
    begin
      st_nxt.tickCnt = st_r.tickCnt + 1'b1;
      st_nxt.tick = 1'b0;
    end

    // Debounce: the count restarts whenever the input returns to the held
    // state, so a level must stay put for a whole interval to be taken.
    for (int i = 0; i < NUM_DIN; i++)
    begin
      if (st_r.dinSync[i] == st_r.dinState[i])
      begin
        st_nxt.cnt[i] = '0;
      end
      else if (st_r.filt[i] == FILT_RST)
      begin
        st_nxt.dinState[i] = st_r.dinSync[i];
        st_nxt.cnt[i] = '0;
      end
      else if (st_r.tick)
      begin
        // One extra tick covers the partial first millisecond.
        if (st_r.cnt[i] >= st_r.filt[i])
        begin
          st_nxt.dinState[i] = st_r.dinSync[i];
          st_nxt.cnt[i] = '0;
        end
        else
        begin
          st_nxt.cnt[i] = st_r.cnt[i] + 1'b1;
        end
      end
    end

    // Interval load touches only the addressed input; out of range is dropped.
    if (filtWrEn && (int'(filtWrIdx) < NUM_DIN))
    begin
      st_nxt.filt[filtWrIdx] = (filtWrTime > FILT_MAX_MS) ? FILT_MAX_MS : filtWrTime;
    end

    // Generators each own one configuration copy that every reader shares.
    for (int g = 0; g < NUM_GEN; g++)
    begin
      sineIdx = '0;
      if (st_r.gen[g].period != 20'h00000)
      begin
        sineIdx = SINE_IDX_W'((26'(st_r.phase[g]) << SINE_IDX_W) / 26'(st_r.gen[g].period));
      end
      unique case (st_r.gen[g].shape)
        SHAPE_RECT:
        begin
          st_nxt.genOut[g] = (st_r.phase[g] < st_r.gen[g].highTime) ?
                             st_r.gen[g].maxLvl : st_r.gen[g].minLvl;
        end
        SHAPE_TRI:
        begin
          if (st_r.phase[g] < st_r.gen[g].riseTime)
          begin
            st_nxt.genOut[g] = rampPoint(st_r.gen[g].minLvl, st_r.gen[g].maxLvl,
                                         st_r.phase[g], st_r.gen[g].riseTime);
          end
          else
          begin
            st_nxt.genOut[g] = rampPoint(st_r.gen[g].maxLvl, st_r.gen[g].minLvl,
                                         st_r.phase[g] - st_r.gen[g].riseTime,
                                         st_r.gen[g].period - st_r.gen[g].riseTime);
          end
        end
        SHAPE_SINE:
        begin
          st_nxt.genOut[g] = rampPoint(st_r.gen[g].minLvl, st_r.gen[g].maxLvl,
                                       20'(sineLut(sineIdx)), SINE_FULL);
        end
        default:
        begin
          st_nxt.genOut[g] = st_r.gen[g].minLvl;
        end
      endcase

      // Phase steps once a millisecond and wraps at the period.
      if (st_r.tick)
      begin
        if (21'(st_r.phase[g]) + 21'h000001 >= 21'(st_r.gen[g].period))
        begin
          st_nxt.phase[g] = '0;
        end
        else
        begin
          st_nxt.phase[g] = st_r.phase[g] + 1'b1;
        end
      end

      flags = limitFlags(st_r.genOut[g], st_r.gen[g].loLim, st_r.gen[g].hiLim);
      st_nxt.genBelow[g] = flags[0];
      st_nxt.genAbove[g] = flags[1];

      // A new configuration restarts the waveform from its start.
      if (genWrEn && (int'(genWrIdx) == g))
      begin
        st_nxt.gen[g] = cfgNew;
        st_nxt.phase[g] = '0;
      end
    end

    // Measured inputs come from logic on this clock and need no sync.
    for (int m = 0; m < NUM_MEAS; m++)
    begin
      flags = limitFlags(measValue[m], measLoLim[m], measHiLim[m]);
      st_nxt.measBelow[m] = flags[0];
      st_nxt.measAbove[m] = flags[1];
    end

    // Thermistor: wide fixed point keeps the cubic term from losing range.
    ntcX = 96'(ntcLnR);
    ntcX3 = ntcX * ntcX * ntcX;
    ntcDen = 96'(ntcCoefA) + ((96'(ntcCoefB) * ntcX) >>> NTC_FRAC_X) +
             ((96'(ntcCoefC) * ntcX3) >>> NTC_SHIFT_C);
    if (ntcDen > 96'sh0)
    begin
      ntcCel = (NTC_NUM / ntcDen) - KELVIN_OFS_DK;
    end
    else
    begin
      ntcCel = 96'(ntcHiLim);
    end
    if (ntcCel < 96'(ntcLoLim))
    begin
      st_nxt.ntcTemp = ntcLoLim;
    end
    else if (ntcCel > 96'(ntcHiLim))
    begin
      st_nxt.ntcTemp = ntcHiLim;
    end
    else
    begin
      st_nxt.ntcTemp = 16'(ntcCel);
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      st_r <= ST_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Every output is a field of the state register.
  assign dinState = st_r.dinState;
  assign genValue = st_r.genOut;
  assign genBelow = st_r.genBelow;
  assign genAbove = st_r.genAbove;
  assign measBelow = st_r.measBelow;
  assign measAbove = st_r.measAbove;
  assign ntcTemp = st_r.ntcTemp;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstN);

  sequence sRectHigh;
    st_r.gen[0].shape == SHAPE_RECT && st_r.phase[0] < st_r.gen[0].highTime;
  endsequence

  sequence sRectLow;
    st_r.gen[0].shape == SHAPE_RECT && st_r.phase[0] >= st_r.gen[0].highTime;
  endsequence

  sequence sWrapPoint;
    st_r.tick && (21'(st_r.phase[0]) + 21'h000001 >= 21'(st_r.gen[0].period));
  endsequence

  AST_FILT_MAX: assert property (st_r.filt[0] <= FILT_MAX_MS)
    else $error("Debounce interval above maximum.");
  AST_PASS_THROUGH: assert property ((st_r.filt[0] == FILT_RST) &&
      (st_r.dinSync[0] != st_r.dinState[0]) |=> st_r.dinState[0] == $past(st_r.dinSync[0]))
    else $error("Unfiltered input did not follow.");
  AST_ACCEPT_LATE: assert property ($changed(st_r.dinState[0]) |->
      $past((st_r.filt[0] == FILT_RST) || (st_r.tick && st_r.cnt[0] >= st_r.filt[0])))
    else $error("Input change accepted before interval elapsed.");
  AST_REVERT_CLEARS: assert property ((st_r.filt[0] != FILT_RST) &&
      (st_r.dinSync[0] == st_r.dinState[0]) |=> st_r.cnt[0] == '0 && $stable(st_r.dinState[0]))
    else $error("Reverted change still counted.");
  AST_FILT_OWN: assert property (filtWrEn && filtWrIdx != 4'h0 |=> $stable(st_r.filt[0]))
    else $error("Interval of another input changed.");
  AST_PHASE_WRAP: assert property (sWrapPoint |=> st_r.phase[0] == '0)
    else $error("Phase did not wrap at period.");
  AST_RECT_HIGH: assert property (sRectHigh |=>
      $signed(st_r.genOut[0]) == $past(st_r.gen[0].maxLvl))
    else $error("Rectangle not at maximum in high time.");
  AST_RECT_LOW: assert property (sRectLow |=>
      $signed(st_r.genOut[0]) == $past(st_r.gen[0].minLvl))
    else $error("Rectangle not at minimum after high time.");
  AST_TRI_PEAK: assert property (st_r.gen[0].shape == SHAPE_TRI &&
      st_r.phase[0] == st_r.gen[0].riseTime && st_r.gen[0].period > st_r.gen[0].riseTime |=>
      $signed(st_r.genOut[0]) == $past(st_r.gen[0].maxLvl))
    else $error("Triangle not at maximum at end of rise.");
  AST_GEN_BELOW: assert property (1'b1 |=>
      st_r.genBelow[0] == $past($signed(st_r.genOut[0]) < st_r.gen[0].loLim))
    else $error("Generator below flag wrong.");
  AST_GEN_ABOVE: assert property (1'b1 |=>
      st_r.genAbove[0] == $past($signed(st_r.genOut[0]) > st_r.gen[0].hiLim))
    else $error("Generator above flag wrong.");
  AST_MEAS_FLAGS: assert property (1'b1 |=>
      measBelow[0] == $past($signed(measValue[0]) < $signed(measLoLim[0])) &&
      measAbove[0] == $past($signed(measValue[0]) > $signed(measHiLim[0])))
    else $error("Measured input limit flags wrong.");
  AST_NTC_CLAMP: assert property (ntcLoLim <= ntcHiLim |=>
      $signed(ntcTemp) >= $past(ntcLoLim) && $signed(ntcTemp) <= $past(ntcHiLim))
    else $error("Thermistor result outside limits.");

endmodule

`default_nettype wire

// file: hdl/input_filter_demo_limits_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants and types for the input conditioning block
// ----------------------------------------------------------------------------
package input_filter_demo_limits_pkg;

  // --------------------------------------------------------------------------
  // Time base
  // --------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_PERIOD_NS = 1_000_000;
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_CNT_W = 24;

  // --------------------------------------------------------------------------
  // Debounce interval, counted in milliseconds
  // --------------------------------------------------------------------------
  localparam int TIME_W = 20;
  localparam int FILT_MAX_S = 1000;
  localparam int MS_PER_S = 1000;
  localparam logic [TIME_W-1:0] FILT_MAX_MS = TIME_W'(FILT_MAX_S * MS_PER_S);
  localparam logic [TIME_W-1:0] FILT_RST = 20'h00000;

  // --------------------------------------------------------------------------
  // Generator shapes and configuration
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SHAPE_RECT = 3'b001,
    SHAPE_TRI = 3'b010,
    SHAPE_SINE = 3'b100
  } shape_t;

  typedef struct packed {
    shape_t shape;
    logic signed [15:0] minLvl;
    logic signed [15:0] maxLvl;
    logic [TIME_W-1:0] period;
    logic [TIME_W-1:0] highTime;
    logic [TIME_W-1:0] riseTime;
    logic signed [15:0] loLim;
    logic signed [15:0] hiLim;
  } genCfg_t;

  localparam genCfg_t GEN_CFG_RST = '{
    shape: SHAPE_RECT,
    minLvl: 16'h0000,
    maxLvl: 16'h03E8,
    period: 20'h02710,
    highTime: 20'h01388,
    riseTime: 20'h01388,
    loLim: 16'h8000,
    hiLim: 16'h7FFF
  };

  // Sine lookup: 64 steps per period, offset value 0..512 around 256.
  localparam int SINE_IDX_W = 6;
  localparam logic [9:0] SINE_MID = 10'h100;
  localparam logic [TIME_W-1:0] SINE_FULL = 20'h00200;

  // --------------------------------------------------------------------------
  // Thermistor conversion scaling
  // --------------------------------------------------------------------------
  localparam int NTC_FRAC_X = 8;
  localparam int NTC_SHIFT_C = 32;
  localparam logic signed [95:0] NTC_NUM = 96'sh0000000A00000000;
  localparam logic signed [95:0] KELVIN_OFS_DK = 96'sh000000000000000000000AAC;

endpackage

// file: verification/contact_model.sv
`timescale 1ns/100ps
`default_nettype none
// Switch contacts and process sensors on the far side of the block.
module contact_model
#(
  parameter int NUM_DIN = 9,
  parameter int NUM_MEAS = 8
)(
  output logic [NUM_DIN-1:0] dinPin, // Contact levels.
  output logic [NUM_MEAS-1:0][15:0] measValue // Sensor readings.
);
  // Contacts start open and sensors read zero until told otherwise.
  initial
  begin
    dinPin = '0;
    measValue = '0;
  end

  // A contact moves only when the bench says so; bounce is built from calls.
  task automatic set_pin(input int idx, input logic lvl);
    dinPin[idx] = lvl;
  endtask

  // A sensor reading changes in one step, as a settled converter would.
  task automatic set_meas(input int ch, input logic [15:0] val);
    measValue[ch] = val;
  endtask
endmodule
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import input_filter_demo_limits_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic filtWrEn = 1'b0;
  logic [3:0] filtWrIdx = 4'h0;
  logic [TIME_W-1:0] filtWrTime = '0;
  logic genWrEn = 1'b0;
  logic [1:0] genWrIdx = 2'h0;
  logic [2:0] genWrShape = 3'h0;
  logic signed [15:0] genWrMin = '0, genWrMax = '0, genWrLoLim = '0, genWrHiLim = '0;
  logic [TIME_W-1:0] genWrPeriod = '0, genWrHigh = '0, genWrRise = '0;
  logic [7:0][15:0] measLoLim = '0, measHiLim = {8{16'h0014}};
  logic signed [15:0] ntcLnR = '0, ntcLoLim = -16'sh0FA0, ntcHiLim = 16'sh0FA0;
  logic signed [31:0] ntcCoefA = 32'h04000000, ntcCoefB = 32'h00001234, ntcCoefC = 32'h00000056;
  logic [8:0] dinPin, dinState;
  logic [7:0][15:0] measValue;
  logic [2:0][15:0] genValue;
  logic [2:0] genBelow, genAbove;
  logic [7:0] measBelow, measAbove;
  logic [15:0] ntcTemp;
  int num_errors = 0;
  int check_count = 0;
  int mn[3] = '{32767, 32767, 32767};
  int mx[3] = '{-32768, -32768, -32768};
  int hiCnt = 0, abCnt = 0, beCnt = 0, k;
  logic seen1 = 1'b0;

  // A 1 ms tick of four clocks keeps every interval short in simulation.
  input_filter_demo_limits #(.TICK_CYCLES(4)) input_filter_demo_limits_i (.*);
  contact_model contact_model_i (.dinPin(dinPin), .measValue(measValue));

  // The 10 MHz clock.
  always #50 core_clk = ~core_clk;

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic filt_wr(input logic [3:0] idx, input logic [TIME_W-1:0] t);
    filtWrIdx = idx;
    filtWrTime = t;
    filtWrEn = 1'b1;
    cyc(1);
    filtWrEn = 1'b0;
    // An idle edge between loads keeps the strobe from toggling in one step.
    cyc(1);
  endtask

  task automatic gen_wr(input logic [1:0] idx, input logic [2:0] shp, input int lo, hi, per, ht,
      rs, loLim, hiLim);
    {genWrIdx, genWrShape, genWrEn} = {idx, shp, 1'b1};
    {genWrMin, genWrMax, genWrLoLim, genWrHiLim} = {16'(lo), 16'(hi), 16'(loLim), 16'(hiLim)};
    {genWrPeriod, genWrHigh, genWrRise} = {TIME_W'(per), TIME_W'(ht), TIME_W'(rs)};
    cyc(1);
    genWrEn = 1'b0;
    cyc(1);
  endtask

  // A bounded wait; running out of cycles is a mismatch and ends the run.
  task automatic wait_pin(input int idx, input int lim, output int n);
    for (n = 1; n <= lim; n++)
    begin
      cyc(1);
      if (dinState[idx] === 1'b1)
        return;
    end
    check(16'h0000, 16'h0001, "input never accepted");
    end_sim();
  endtask

  // Main sequence: reset, debounce, generators, limits, thermistor.
  initial
  begin
    cyc(6);
    resetn = 1'b1;
    cyc(2);
    check(16'(dinState), 16'h0000, "din after reset");
    check(genValue[0], 16'h0000, "gen after reset");
    cyc(1);
    contact_model_i.set_pin(0, 1'b1);
    cyc(2);
    check(16'(dinState[0]), 16'h0000, "pass too early");
    cyc(1);
    check(16'(dinState[0]), 16'h0001, "pass through");
    $display("Test passthrough done");
    filt_wr(4'h1, 20'h00002);
    filt_wr(4'h9, 20'h00000);
    contact_model_i.set_pin(1, 1'b1);
    contact_model_i.set_pin(2, 1'b1);
    cyc(3);
    check(16'(dinState[2:1]), 16'h0002, "own interval");
    cyc(3);
    contact_model_i.set_pin(1, 1'b0);
    cyc(20);
    check(16'(dinState[1]), 16'h0000, "short pulse shown");
    contact_model_i.set_pin(1, 1'b1);
    wait_pin(1, 20, k);
    check(16'(k >= 11 && k <= 14), 16'h0001, "accept delay");
    filt_wr(4'h1, 20'hF4240);
    contact_model_i.set_pin(1, 1'b0);
    cyc(40);
    check(16'(dinState[1]), 16'h0001, "long interval");
    $display("Test debounce done");
    gen_wr(2'h0, SHAPE_RECT, -10, 50, 4, 2, 1, 0, 40);
    cyc(1);
    check(genValue[0], 16'h0032, "rect starts high");
    gen_wr(2'h1, SHAPE_TRI, 0, 100, 4, 1, 2, 10, 90);
    gen_wr(2'h2, SHAPE_SINE, -100, 100, 8, 1, 1, -200, 200);
    gen_wr(2'h3, SHAPE_TRI, 7, 9, 3, 1, 1, 0, 0);
    cyc(2);
    for (int c = 0; c < 64; c++)
    begin
      cyc(1);
      for (int g = 0; g < 3; g++)
      begin
        mn[g] = ($signed(genValue[g]) < mn[g]) ? $signed(genValue[g]) : mn[g];
        mx[g] = ($signed(genValue[g]) > mx[g]) ? $signed(genValue[g]) : mx[g];
      end
      hiCnt += int'(genValue[0] === 16'h0032);
      abCnt += int'(genAbove[0] === 1'b1);
      beCnt += int'(genBelow[0] === 1'b1);
      seen1 |= genAbove[1] & 1'b1;
    end
    check(16'(mn[0]), -16'sh000A, "rect min");
    check(16'(mx[0]), 16'h0032, "rect max");
    check(16'(hiCnt), 16'h0020, "rect high time");
    check(16'(abCnt), 16'h0020, "rect above");
    check(16'(beCnt), 16'h0020, "rect below");
    check(16'(mn[1]), 16'h0000, "tri min");
    check(16'(mx[1]), 16'h0064, "tri max");
    check(16'(seen1), 16'h0001, "tri above");
    check(16'(mn[2] >= -100 && mx[2] <= 100 && mx[2] > mn[2]), 16'h0001, "sine span");
    gen_wr(2'h2, 3'h0, 5, 9, 4, 1, 1, 0, 0);
    cyc(2);
    check(genValue[2], 16'h0005, "unknown shape gives min");
    $display("Test generators done");
    for (int i = 0; i < 8; i++)
      contact_model_i.set_meas(i, 16'(i * 10 - 30));
    cyc(2);
    for (int i = 0; i < 8; i++)
      check(16'({measBelow[i], measAbove[i]}), 16'({i < 3, i > 5}), "meas flags");
    $display("Test limits done");
    check(ntcTemp, -16'sh082C, "coefficient result");
    // ln R of 4 with a large cubic term, so both B and C move the result.
    ntcLnR = 16'sh0400;
    ntcCoefC = 32'h00100000;
    cyc(2);
    check(ntcTemp, -16'sh082F, "linear and cubic terms");
    ntcLnR = '0;
    ntcLoLim = -16'sh03E8;
    cyc(2);
    check(ntcTemp, -16'sh03E8, "low clamp");
    ntcCoefA = 32'h00000000;
    cyc(2);
    check(ntcTemp, 16'h0FA0, "bad denominator");
    $display("Test thermistor done");
    end_sim();
  end
endmodule
`default_nettype wire
